// file: src/boot_entry_pkg.sv
// shared constants, message texts and helpers for the serial loader entry link
package boot_entry_pkg;
   localparam int CLK_HZ      = 50_000_000;
   localparam int BAUD        = 115200;
   localparam int BIT_CYC     = CLK_HZ / BAUD;
   localparam int HALF_CYC    = BIT_CYC / 2;
   localparam int DATA_BITS   = 8;
   localparam int FRAME_BITS  = 10;
   localparam int SETTLE_CYC  = 4;
   localparam int TIMEOUT_S   = 60;
   localparam int C_PERIOD_MS = 3000;
   localparam int HOST_RST_CYC = 16;
   localparam int HOST_GAP_CYC = 2 * BIT_CYC;
   localparam logic [31:0] BREAK_CYC_DEF   = 32'((FRAME_BITS + 1) * BIT_CYC);
   localparam logic [31:0] TIMEOUT_CYC_DEF = 32'(64'(TIMEOUT_S) * 64'(CLK_HZ));
   localparam logic [31:0] C_PERIOD_DEF    = 32'(64'(C_PERIOD_MS) * 64'(CLK_HZ) / 64'd1000);
   localparam logic [31:0] HOST_HOLD_DEF   = 32'(2 * (FRAME_BITS + 1) * BIT_CYC);

   localparam logic [7:0] CH_CR    = 8'h0D;
   localparam logic [7:0] CH_LF    = 8'h0A;
   localparam logic [7:0] CH_LOAD  = 8'h31;
   localparam logic [7:0] CH_RUN   = 8'h32;
   localparam logic [7:0] CH_SOH   = 8'h01;
   localparam logic [7:0] CH_EOT   = 8'h04;
   localparam logic [7:0] CH_ACK   = 8'h06;
   localparam logic [7:0] CH_NAK   = 8'h15;
   localparam logic [7:0] CH_CRC_C = 8'h43;
   localparam logic [15:0] CRC_POLY = 16'h1021;

   localparam logic [7:0] POS_BLK   = 8'h01;
   localparam logic [7:0] POS_INV   = 8'h02;
   localparam logic [7:0] POS_DATA0 = 8'h03;
   localparam logic [7:0] POS_DATAN = 8'h82;
   localparam logic [7:0] POS_CRCH  = 8'h83;
   localparam logic [7:0] POS_CRCL  = 8'h84;

   localparam int PROMPT_LEN = 6;
   localparam int DONE_LEN   = 11;
   localparam int ABORT_LEN  = 9;
   localparam logic [8*PROMPT_LEN-1:0] LOADER_PROMPT = {CH_CR, CH_LF, "BL >"};
   localparam logic [8*DONE_LEN-1:0]   DONE_TXT      = {CH_ACK, CH_CR, CH_LF, "complete"};
   localparam logic [8*ABORT_LEN-1:0]  ABORT_TXT     = {CH_CR, CH_LF, "aborted"};

   typedef enum logic [2:0] {MSG_PROMPT, MSG_DONE, MSG_ABORT, MSG_ACK, MSG_NAK, MSG_CRC_C} msg_t;

   function automatic logic [3:0] msg_len(input msg_t m);
      unique case (m)
         MSG_PROMPT: msg_len = 4'(PROMPT_LEN);
         MSG_DONE:   msg_len = 4'(DONE_LEN);
         MSG_ABORT:  msg_len = 4'(ABORT_LEN);
         default:    msg_len = 4'h1;
      endcase
   endfunction

   function automatic logic [7:0] msg_char(input msg_t m, input logic [3:0] i);
      unique case (m)
         MSG_PROMPT: msg_char = LOADER_PROMPT[8*(PROMPT_LEN-1-int'(i)) +: 8];
         MSG_DONE:   msg_char = DONE_TXT[8*(DONE_LEN-1-int'(i)) +: 8];
         MSG_ABORT:  msg_char = ABORT_TXT[8*(ABORT_LEN-1-int'(i)) +: 8];
         MSG_ACK:    msg_char = CH_ACK;
         MSG_NAK:    msg_char = CH_NAK;
         default:    msg_char = CH_CRC_C;
      endcase
   endfunction

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {d, 8'h00};
      for (int k = 0; k < DATA_BITS; k++) begin
         r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction
endpackage

// file: src/boot_link_if.sv
// serial and handshake lines between host controller and loader device
`timescale 1ns/10ps
`default_nettype none
interface boot_link_if;
   logic dev_rxd;
   logic dev_txd;
   logic sleep_request_pin;
   logic rts;
   logic dev_reset_req;
   modport device(input dev_rxd, input sleep_request_pin, input rts, input dev_reset_req, output dev_txd);
   modport host(output dev_rxd, output sleep_request_pin, output rts, output dev_reset_req, input dev_txd);
endinterface
`default_nettype wire

// file: src/boot_entry_device.sv
// loader entry device end with uart, two-word buffer and xmodem-crc receiver
//
// Overview of operation
// - host drives sleep request low, rts high
// - host holds break while resetting the module
// - entry pattern sampled right after reset
// - host releases break, sends carriage return
// - device sends loader prompt, then takes commands
// - all characters are 8N1
// - host uses no hardware flow control
// - image arrives by xmodem after loader runs
// - no valid application forces the loader
// - software request enters loader, never returns (here '2' at the menu returns to the application)
// - '1' starts xmodem-crc upload, blocks in order
// - no first block in one minute aborts
// - completion reported; '2' starts new application
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module ser_rx
   import boot_entry_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       rxd,
   output logic      [7:0] data,
   output logic            valid
);
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP, RX_WAIT_HIGH} rx_state_t;
   rx_state_t   st_ff;
   logic [15:0] cnt_ff;
   logic [2:0]  bit_ff;
   logic [7:0]  sh_ff;
   wire         half_done = cnt_ff == 16'(HALF_CYC - 1);
   wire         bit_done  = cnt_ff == 16'(BIT_CYC - 1);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_ff <= RX_IDLE; cnt_ff <= '0; bit_ff <= '0; sh_ff <= '0; data <= '0; valid <= 1'b0;
      end else begin
         valid  <= 1'b0;
         cnt_ff <= cnt_ff + 16'h0001;
         unique case (st_ff)
            RX_IDLE: begin
               cnt_ff <= '0;
               if (!rxd) st_ff <= RX_START;
            end
            RX_START: if (half_done) begin
               cnt_ff <= '0; bit_ff <= '0;
               st_ff  <= rxd ? RX_IDLE : RX_BITS;
            end
            RX_BITS: if (bit_done) begin
               cnt_ff <= '0; sh_ff <= {rxd, sh_ff[7:1]}; bit_ff <= bit_ff + 3'h1;
               if (bit_ff == 3'(DATA_BITS - 1)) st_ff <= RX_STOP;
            end
            // one stop bit; a low stop drops the frame
            RX_STOP: if (bit_done) begin
               if (rxd) begin
                  data <= sh_ff; valid <= 1'b1; st_ff <= RX_IDLE;
               end else begin
                  st_ff <= RX_WAIT_HIGH;
               end
            end
            RX_WAIT_HIGH: if (rxd) st_ff <= RX_IDLE;
         endcase
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module boot_entry_device
   import boot_entry_pkg::*;
#(
   parameter logic [31:0] BREAK_CYCLES   = BREAK_CYC_DEF,
   parameter logic [31:0] TIMEOUT_CYCLES = TIMEOUT_CYC_DEF,
   parameter logic [31:0] C_PERIOD_CYCLES = C_PERIOD_DEF
) (
   input  wire logic       clk,
   input  wire logic       reset,
   boot_link_if.device     lk,
   input  wire logic       app_valid,
   input  wire logic       sw_boot_req,
   output logic            app_run,
   output logic            loader_active,
   output logic      [7:0] image_data,
   output logic            image_we,
   output logic      [7:0] image_blk,
   output logic            image_ok,
   output logic            image_bad
);
   typedef enum logic [2:0] {ST_SAMPLE, ST_BREAK, ST_WAIT_CR, ST_SEND, ST_MENU, ST_XM_WAIT,
                             ST_XM_BLK, ST_APP} state_t;
   state_t      st_ff, nxt_st, ret_ff, nxt_ret;
   msg_t        msg_ff, nxt_msg;
   logic [3:0]  idx_ff, nxt_idx;
   logic [31:0] tmr_ff, nxt_tmr, cp_ff, nxt_cp;
   logic [7:0]  pos_ff, nxt_pos, blk_ff, nxt_blk, got_ff, nxt_got;
   logic [15:0] crc_ff, nxt_crc;
   logic        hdr_ok_ff, nxt_hdr_ok, nxt_app, nxt_loader, nxt_we, nxt_ok, nxt_bad;
   logic [3:0]  sync1_ff, sync2_ff;
   logic [7:0]  rx_dat, b_dat;
   logic        rx_vld, b_vld, tx_busy;

   wire rx_l    = sync2_ff[3];
   wire slp_l   = sync2_ff[2];
   wire rts_l   = sync2_ff[1];
   wire rst_req = sync2_ff[0];
   wire entry_pat = !slp_l && !rx_l && rts_l;
   wire b_rdy   = st_ff inside {ST_WAIT_CR, ST_MENU, ST_XM_WAIT, ST_XM_BLK};
   wire take    = b_vld && b_rdy;
   wire tx_go   = (st_ff == ST_SEND) && !tx_busy;
   wire last_chr = idx_ff == msg_len(msg_ff) - 4'h1;
   wire is_data = (pos_ff >= POS_DATA0) && (pos_ff <= POS_DATAN);
   wire blk_new = got_ff == blk_ff;
   wire blk_dup = got_ff == blk_ff - 8'h01;
   wire crc_good = hdr_ok_ff && (b_dat == crc_ff[7:0]);
   wire loading = (st_ff == ST_XM_WAIT) || (st_ff == ST_SEND && ret_ff == ST_XM_WAIT);

   ser_rx u_rx (.clk(clk), .reset(reset), .rxd(rx_l), .data(rx_dat), .valid(rx_vld));
   word_fifo #(.WIDTH(8), .DEPTH(2)) u_buf (
      .clk(clk), .reset(reset), .in_valid(rx_vld), .in_data(rx_dat), .in_ready(),
      .out_valid(b_vld), .out_data(b_dat), .out_ready(b_rdy));
   ser_tx u_tx (.clk(clk), .reset(reset), .start(tx_go), .data(msg_char(msg_ff, idx_ff)), .brk(1'b0),
      .busy(tx_busy), .txd(lk.dev_txd));

   always_comb begin
      nxt_st = st_ff; nxt_ret = ret_ff; nxt_msg = msg_ff; nxt_idx = idx_ff;
      nxt_tmr = tmr_ff; nxt_cp = cp_ff; nxt_pos = pos_ff; nxt_blk = blk_ff; nxt_got = got_ff;
      nxt_crc = crc_ff; nxt_hdr_ok = hdr_ok_ff; nxt_app = app_run; nxt_loader = loader_active;
      nxt_we = 1'b0; nxt_ok = 1'b0; nxt_bad = 1'b0;
      if (loading) nxt_tmr = tmr_ff + 32'h1;
      unique case (st_ff)
         // sample the entry pattern after settling
         ST_SAMPLE: begin
            nxt_tmr = tmr_ff + 32'h1;
            if (tmr_ff == 32'(SETTLE_CYC)) begin
               nxt_tmr = '0;
               if (entry_pat) nxt_st = ST_BREAK;
               else if (!app_valid) begin
                  nxt_st = ST_SEND; nxt_msg = MSG_PROMPT; nxt_ret = ST_MENU; nxt_loader = 1'b1;
               end else begin
                  nxt_st = ST_APP; nxt_app = 1'b1;
               end
            end
         end
         // break is low past one frame
         ST_BREAK: begin
            nxt_tmr = tmr_ff + 32'h1;
            if (rx_l) begin
               nxt_st = app_valid ? ST_APP : ST_SEND; nxt_app = app_valid; nxt_loader = !app_valid;
               nxt_msg = MSG_PROMPT; nxt_ret = ST_MENU;
            end else if (tmr_ff == BREAK_CYCLES - 32'h1) begin
               nxt_st = ST_WAIT_CR; nxt_loader = 1'b1;
            end
         end
         ST_WAIT_CR: if (take && b_dat == CH_CR) begin
            nxt_st = ST_SEND; nxt_msg = MSG_PROMPT; nxt_ret = ST_MENU;
         end
         ST_SEND: if (tx_go) begin
            nxt_idx = last_chr ? 4'h0 : idx_ff + 4'h1;
            if (last_chr) nxt_st = ret_ff;
         end
         ST_MENU: if (take) begin
            if (b_dat == CH_LOAD) begin
               nxt_st = ST_SEND; nxt_msg = MSG_CRC_C; nxt_ret = ST_XM_WAIT;
               nxt_tmr = '0; nxt_cp = '0; nxt_blk = 8'h01;
            end else if (b_dat == CH_RUN) begin
               nxt_st = ST_APP; nxt_app = 1'b1; nxt_loader = 1'b0;
            end else if (b_dat == CH_CR) begin
               nxt_st = ST_SEND; nxt_msg = MSG_PROMPT; nxt_ret = ST_MENU;
            end
         end
         ST_XM_WAIT: begin
            nxt_cp = cp_ff + 32'h1;
            if (take && b_dat == CH_SOH) begin
               nxt_st = ST_XM_BLK; nxt_pos = POS_BLK; nxt_crc = '0;
            // one minute without a first block aborts
            end else if (tmr_ff >= TIMEOUT_CYCLES - 32'h1) begin
               nxt_st = ST_SEND; nxt_msg = MSG_ABORT; nxt_ret = ST_MENU;
            end else if (cp_ff == C_PERIOD_CYCLES - 32'h1) begin
               nxt_cp = '0; nxt_st = ST_SEND; nxt_msg = MSG_CRC_C; nxt_ret = ST_XM_WAIT;
            end
         end
         // xmodem block framing, crc and reply
         ST_XM_BLK: if (take) begin
            nxt_pos = pos_ff + 8'h01;
            if (pos_ff == '0) begin
               nxt_crc = '0;
               if (b_dat == CH_SOH) nxt_pos = POS_BLK;
               else begin
                  nxt_pos = '0;
                  if (b_dat == CH_EOT) begin
                     nxt_st = ST_SEND; nxt_msg = MSG_DONE; nxt_ret = ST_MENU;
                  end
               end
            end else if (pos_ff == POS_BLK) nxt_got = b_dat;
            else if (pos_ff == POS_INV) nxt_hdr_ok = b_dat == ~got_ff;
            else if (is_data) begin
               nxt_crc = crc_step(crc_ff, b_dat);
               // only the expected block reaches the image
               nxt_we = blk_new;
            end else if (pos_ff == POS_CRCH) nxt_hdr_ok = hdr_ok_ff && (b_dat == crc_ff[15:8]);
            else begin
               nxt_pos = '0; nxt_st = ST_SEND; nxt_ret = ST_XM_BLK;
               nxt_msg = (crc_good && (blk_new || blk_dup)) ? MSG_ACK : MSG_NAK;
               nxt_ok  = crc_good && blk_new;
               nxt_bad = !crc_good && blk_new;
               if (crc_good && blk_new) nxt_blk = blk_ff + 8'h01;
            end
         end
         // software request enters the loader; '2' at the menu returns to the application
         ST_APP: if (sw_boot_req) begin
            nxt_st = ST_SEND; nxt_msg = MSG_PROMPT; nxt_ret = ST_MENU; nxt_app = 1'b0; nxt_loader = 1'b1;
         end
      endcase
      if (rst_req) begin
         nxt_st = ST_SAMPLE; nxt_tmr = '0; nxt_idx = '0; nxt_app = 1'b0; nxt_loader = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1_ff <= 4'hD; sync2_ff <= 4'hD;
         st_ff <= ST_SAMPLE; ret_ff <= ST_MENU; msg_ff <= MSG_PROMPT; idx_ff <= '0;
         tmr_ff <= '0; cp_ff <= '0; pos_ff <= '0; blk_ff <= 8'h01; got_ff <= '0; crc_ff <= '0;
         hdr_ok_ff <= 1'b0; app_run <= 1'b0; loader_active <= 1'b0;
         image_data <= '0; image_we <= 1'b0; image_blk <= '0; image_ok <= 1'b0; image_bad <= 1'b0;
      end else begin
         sync1_ff <= {lk.dev_rxd, lk.sleep_request_pin, lk.rts, lk.dev_reset_req};
         sync2_ff <= sync1_ff;
         st_ff <= nxt_st; ret_ff <= nxt_ret; msg_ff <= nxt_msg; idx_ff <= nxt_idx;
         tmr_ff <= nxt_tmr; cp_ff <= nxt_cp; pos_ff <= nxt_pos; blk_ff <= nxt_blk; got_ff <= nxt_got;
         crc_ff <= nxt_crc; hdr_ok_ff <= nxt_hdr_ok; app_run <= nxt_app; loader_active <= nxt_loader;
         image_we <= nxt_we; image_ok <= nxt_ok; image_bad <= nxt_bad; image_blk <= got_ff;
         if (nxt_we) image_data <= b_dat;
      end
   end
endmodule
`default_nettype wire

// file: src/boot_entry_host.sv
// host controller end: entry sequence, then a buffered byte channel
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module word_fifo
   import boot_entry_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wp_ff;
   logic [AW-1:0]    rp_ff;
   logic [AW:0]      cnt_ff;
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;
   wire  [AW:0]      nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
   wire  [AW-1:0]    nxt_wp  = (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
   wire  [AW-1:0]    nxt_rp  = (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
   assign out_data = mem_ff[rp_ff];
   always_ff @(posedge clk) begin
      if (push) mem_ff[wp_ff] <= in_data;
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wp_ff <= '0; rp_ff <= '0; cnt_ff <= '0; in_ready <= 1'b1; out_valid <= 1'b0;
      end else begin
         if (push) wp_ff <= nxt_wp;
         if (pop) rp_ff <= nxt_rp;
         cnt_ff    <= nxt_cnt;
         in_ready  <= nxt_cnt != (AW+1)'(DEPTH);
         out_valid <= nxt_cnt != '0;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module ser_tx
   import boot_entry_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       start,
   input  wire logic [7:0] data,
   input  wire logic       brk,
   output logic            busy,
   output logic            txd
);
   logic [FRAME_BITS-1:0] sh_ff;
   logic [3:0]            nbit_ff;
   logic [15:0]           cnt_ff;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sh_ff <= '1; nbit_ff <= '0; cnt_ff <= '0; busy <= 1'b0; txd <= 1'b1;
      end else begin
         txd <= brk ? 1'b0 : sh_ff[0];
         if (!busy) begin
            if (start) begin
               busy <= 1'b1; sh_ff <= {1'b1, data, 1'b0}; nbit_ff <= '0; cnt_ff <= '0;
            end
         end else if (cnt_ff == 16'(BIT_CYC - 1)) begin
            cnt_ff  <= '0;
            sh_ff   <= {1'b1, sh_ff[FRAME_BITS-1:1]};
            nbit_ff <= nbit_ff + 4'h1;
            if (nbit_ff == 4'(FRAME_BITS - 1)) busy <= 1'b0;
         end else begin
            cnt_ff <= cnt_ff + 16'h0001;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module boot_entry_host
   import boot_entry_pkg::*;
#(
   parameter logic [31:0] HOLD_CYCLES = HOST_HOLD_DEF
) (
   input  wire logic       clk,
   input  wire logic       reset,
   boot_link_if.host       lk,
   input  wire logic       enter_req,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   output logic      [7:0] rx_data,
   output logic            rx_valid,
   output logic            link_ready
);
   typedef enum logic [2:0] {H_IDLE, H_RESET, H_HOLD, H_GAP, H_CR, H_LINK} hstate_t;
   hstate_t     st_ff;
   logic [31:0] cnt_ff;
   logic        brk_ff;
   logic [1:0]  rsync_ff;
   logic [7:0]  f_dat;
   logic        f_vld, tx_busy;
   wire         f_rdy  = (st_ff == H_LINK) && !tx_busy;
   wire         cr_go  = (st_ff == H_CR) && !tx_busy;
   wire         tx_go  = cr_go || (f_rdy && f_vld);

   word_fifo #(.WIDTH(8), .DEPTH(2)) u_buf (
      .clk(clk), .reset(reset), .in_valid(tx_valid), .in_data(tx_data), .in_ready(tx_ready),
      .out_valid(f_vld), .out_data(f_dat), .out_ready(f_rdy));
   ser_tx u_tx (.clk(clk), .reset(reset), .start(tx_go), .data(cr_go ? CH_CR : f_dat), .brk(brk_ff),
      .busy(tx_busy), .txd(lk.dev_rxd));
   ser_rx u_rx (.clk(clk), .reset(reset), .rxd(rsync_ff[1]), .data(rx_data), .valid(rx_valid));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_ff <= H_IDLE; cnt_ff <= '0; brk_ff <= 1'b0; rsync_ff <= 2'h3; link_ready <= 1'b0;
         lk.sleep_request_pin <= 1'b1; lk.rts <= 1'b0; lk.dev_reset_req <= 1'b0;
      end else begin
         rsync_ff <= {rsync_ff[0], lk.dev_txd};
         cnt_ff   <= cnt_ff + 32'h1;
         unique case (st_ff)
            // pins set, break held, module reset
            H_IDLE: if (enter_req) begin
               lk.sleep_request_pin <= 1'b0; lk.rts <= 1'b1; brk_ff <= 1'b1;
               link_ready <= 1'b0; cnt_ff <= '0; st_ff <= H_RESET;
            end
            // pattern stays while the module comes up
            H_RESET: begin
               // break reaches the line in the same cycle as the restart starts
               if (cnt_ff == '0) lk.dev_reset_req <= 1'b1;
               if (cnt_ff == 32'(HOST_RST_CYC)) begin
                  lk.dev_reset_req <= 1'b0; cnt_ff <= '0; st_ff <= H_HOLD;
               end
            end
            H_HOLD: if (cnt_ff == HOLD_CYCLES - 32'h1) begin
               brk_ff <= 1'b0; cnt_ff <= '0; st_ff <= H_GAP;
            end
            H_GAP: if (cnt_ff == 32'(HOST_GAP_CYC - 1)) st_ff <= H_CR;
            // single carriage return after the break
            H_CR: if (cr_go) begin
               st_ff <= H_LINK; link_ready <= 1'b1;
            end
            // rts stays high, no flow control
            H_LINK: if (enter_req) begin
               brk_ff <= 1'b1; link_ready <= 1'b0; cnt_ff <= '0; st_ff <= H_RESET;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// file: tb/boot_link_asserts.sv
// wire-level checks of the loader entry link between host and device ends
`timescale 1ns/10ps
`default_nettype none
module boot_link_asserts
   import boot_entry_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic dev_rxd,
   input wire logic dev_txd,
   input wire logic sleep_request_pin,
   input wire logic rts,
   input wire logic dev_reset_req
);
   localparam logic [12:0] STOP_AT = 13'(9 * BIT_CYC + HALF_CYC);
   localparam logic [12:0] MID_AT  = 13'(HALF_CYC);
   logic [12:0] tx_cnt_ff;
   logic [12:0] nxt_tx_cnt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   // position inside a device frame, 0 while idle
   assign nxt_tx_cnt = (tx_cnt_ff == 13'h0) ? {12'h0, ~dev_txd} :
                       ((tx_cnt_ff == STOP_AT) ? 13'h0 : tx_cnt_ff + 13'h1);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_cnt_ff <= 13'h0;
      end else begin
         tx_cnt_ff <= nxt_tx_cnt;
      end
   end
   sequence s_req_pulse;
      dev_reset_req [*8] ##8 dev_reset_req ##1 !dev_reset_req;
   endsequence
   a_idle_release: assert property ($fell(reset) |-> dev_txd && dev_rxd)
      else $error("link not idle after reset");
   a_entry_levels: assert property (dev_reset_req |-> !dev_rxd && !sleep_request_pin && rts)
      else $error("entry pattern not held during restart");
   a_reset_pulse: assert property ($rose(dev_reset_req) |-> s_req_pulse)
      else $error("restart pulse not sixteen cycles");
   a_break_after: assert property ($fell(dev_reset_req) |-> (!dev_rxd) [*8])
      else $error("break released too early");
   a_quiet_entry: assert property ($fell(dev_reset_req) |-> dev_txd [*8])
      else $error("device sent during break");
   a_rts_steady: assert property ($changed(rts) |-> ##1 $rose(dev_reset_req))
      else $error("flow control line moved");
   a_tx_start_bit: assert property (tx_cnt_ff == MID_AT |-> !dev_txd)
      else $error("short start bit on device output");
   a_tx_stop_bit: assert property (tx_cnt_ff == STOP_AT |-> dev_txd)
      else $error("missing stop bit on device output");
endmodule
`default_nettype wire

// file: tb/serial_bootloader_entry_bench.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/10ps
`default_nettype none
module serial_bootloader_entry_bench import boot_entry_pkg::*;;
   logic       clk;
   logic       reset;
   logic       app_valid;
   logic       sw_boot_req;
   logic       enter_req;
   logic [7:0] tx_data;
   logic       tx_valid;
   logic       tx_ready;
   logic [7:0] rx_data;
   logic       rx_valid;
   logic       link_ready;
   logic       app_run;
   logic       loader_active;
   logic [7:0] rxq[$];
   int         n_fail;
   int         n_checks;
   boot_link_if lk_if ();
   boot_entry_device #(.BREAK_CYCLES(32'h28), .TIMEOUT_CYCLES(32'h3A98), .C_PERIOD_CYCLES(32'h1F40))
      boot_entry_device_inst (.clk(clk), .reset(reset), .lk(lk_if), .app_valid(app_valid),
      .sw_boot_req(sw_boot_req), .app_run(app_run), .loader_active(loader_active), .image_data(),
      .image_we(), .image_blk(), .image_ok(), .image_bad());
   boot_entry_host #(.HOLD_CYCLES(32'h3C)) boot_entry_host_inst (.clk(clk), .reset(reset), .lk(lk_if),
      .enter_req(enter_req), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
      .rx_valid(rx_valid), .link_ready(link_ready));
   boot_link_asserts boot_link_asserts_inst (.clk(clk), .reset(reset), .dev_rxd(lk_if.dev_rxd),
      .dev_txd(lk_if.dev_txd), .sleep_request_pin(lk_if.sleep_request_pin), .rts(lk_if.rts),
      .dev_reset_req(lk_if.dev_reset_req));
   ////////////////////////////////////////////////////////////////////////////////
   always #10 clk = ~clk;
   always @(posedge clk) begin
      if (rx_valid === 1'b1) rxq.push_back(rx_data);
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic send_byte(input logic [7:0] d);
      @(posedge clk);
      #1 tx_data = d;
      tx_valid = 1'b1;
      do @(posedge clk); while (tx_ready !== 1'b1);
      #1 tx_valid = 1'b0;
   endtask
   task automatic expect_text(input logic [8*DONE_LEN-1:0] s, input int n);
      int k;
      for (int i = n - 1; i >= 0; i--) begin
         for (k = 0; k < 20000 && rxq.size() == 0; k++) @(posedge clk);
         if (rxq.size() == 0) begin
            n_fail++;
            $display("[ERR] rx byte expected %h seen none", s[8*i +: 8]);
            return;
         end
         check("rx byte", rxq.pop_front(), s[8*i +: 8]);
      end
   endtask
   task automatic wait_for(ref logic s, input int lim);
      for (int k = 0; k < lim && s !== 1'b1; k++) @(posedge clk);
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #(130000 * 20);
      n_fail++;
      report_and_stop();
   end
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      app_valid = 1'b1;
      sw_boot_req = 1'b0;
      enter_req = 1'b0;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      wait_for(app_run, 100);
      check("app_run", {7'h0, app_run}, 8'h01);
      check("idle link", {6'h0, lk_if.dev_rxd, lk_if.dev_txd}, 8'h03);
      @(posedge clk);
      #1 enter_req = 1'b1;
      @(posedge clk);
      #1 enter_req = 1'b0;
      repeat (4) @(posedge clk);
      check("entry pins", {5'h0, lk_if.sleep_request_pin, lk_if.rts, lk_if.dev_rxd}, 8'h02);
      expect_text(88'(LOADER_PROMPT), PROMPT_LEN);
      check("loader_active", {7'h0, loader_active}, 8'h01);
      send_byte(CH_LOAD);
      expect_text(88'(CH_CRC_C), 1);
      // end of transfer before any block is ignored
      send_byte(CH_EOT);
      expect_text(88'(CH_CRC_C), 1);
      expect_text(88'(ABORT_TXT), ABORT_LEN);
      send_byte(CH_RUN);
      wait_for(app_run, 6000);
      check("run after load", {6'h0, app_run, loader_active}, 8'h02);
      @(posedge clk);
      #1 sw_boot_req = 1'b1;
      @(posedge clk);
      #1 sw_boot_req = 1'b0;
      wait_for(loader_active, 100);
      check("software entry", {6'h0, app_run, loader_active}, 8'h01);
      report_and_stop();
   end
endmodule
`default_nettype wire
